// *** pwm_gen_channels.sv ***
// Two PWM generator channels (B and C) with their timing I/O registers and channel C's control register
`timescale 1ns/100ps
module pwm_gen_channels (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Core I/O access
  input pwm_gen_pkg::io_req_t io_req,
  output logic [7:0] io_rdata,
  // Fast RC oscillator tick, one cycle wide
  input wire logic osc_tick,
  // Channel B control bits, held elsewhere
  input pwm_gen_pkg::chan_ctl_t chan_b_ctl,
  // Channel outputs, index 0 is B, 1 is C
  output logic [1:0] pwm_level,
  output logic [1:0] irq_pulse,
  // Pins: B uses 0..2, C uses 0..3
  output logic [1:0][3:0] pin_out,
  output logic [1:0][3:0] pin_oe
);

  // Prescaler terminal count for a code
  function automatic logic [5:0] pre_end(input logic [1:0] code);
    unique case (code)
      2'h0: pre_end = pwm_gen_pkg::PRE_END_1;
      2'h1: pre_end = pwm_gen_pkg::PRE_END_4;
      2'h2: pre_end = pwm_gen_pkg::PRE_END_16;
      2'h3: pre_end = pwm_gen_pkg::PRE_END_64;
    endcase
  endfunction : pre_end

  // One-hot pin map; reserved codes drive nothing
  function automatic logic [3:0] pin_map(input logic [2:0] sel);
    unique case (sel)
      pwm_gen_pkg::SEL_PIN0: pin_map = 4'h1;
      pwm_gen_pkg::SEL_PIN1: pin_map = 4'h2;
      pwm_gen_pkg::SEL_PIN2: pin_map = 4'h4;
      pwm_gen_pkg::SEL_PIN3: pin_map = 4'h8;
      default: pin_map = 4'h0;
    endcase
  endfunction : pin_map

  // Address match for a write
  function automatic logic wr_at(input pwm_gen_pkg::io_req_t r,
                                 input logic [5:0] a);
    wr_at = r.wr && (r.addr == a);
  endfunction : wr_at

  // Register state
  pwm_gen_pkg::chan_cfg_t [1:0] cfg_q; // Timing setup per channel
  pwm_gen_pkg::chan_ctl_t ctl_c_q; // Channel C control
  pwm_gen_pkg::chan_ctl_t [1:0] ctl; // Control seen by each channel
  // Counting state
  logic [1:0][5:0] pre_cnt_q; // Prescaler
  logic [1:0][4:0] div_cnt_q; // Divider
  logic [1:0][10:0] cnt_q; // Main counter
  // Combinational helpers
  logic [1:0] src_tick; // Selected source edge
  logic [1:0] pre_wrap; // Prescaler terminal
  logic [1:0] tick; // Counter step
  logic [1:0] run; // Enabled and not clearing
  logic [1:0][10:0] cnt_nxt; // Counter after a step
  logic [1:0][10:0] cnt_d; // Count after this edge
  logic [7:0] io_rdata_q;

  assign io_rdata = io_rdata_q;
  assign ctl[pwm_gen_pkg::CH_B] = chan_b_ctl;
  assign ctl[pwm_gen_pkg::CH_C] = ctl_c_q;

  // Timing registers; bound applies at once
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      cfg_q <= '0;
    end else begin
      // Prescale: mode, prescaler code, divider
      if (wr_at(io_req, pwm_gen_pkg::ADDR_B_PRESCALE)) begin
        cfg_q[0].mode <= io_req.wdata[pwm_gen_pkg::PS_MODE];
        cfg_q[0].pre <= io_req.wdata[pwm_gen_pkg::PS_PRE_HI:pwm_gen_pkg::PS_PRE_LO];
        cfg_q[0].div <= io_req.wdata[pwm_gen_pkg::PS_DIV_HI:pwm_gen_pkg::PS_DIV_LO];
      end
      if (wr_at(io_req, pwm_gen_pkg::ADDR_C_PRESCALE)) begin
        cfg_q[1].mode <= io_req.wdata[pwm_gen_pkg::PS_MODE];
        cfg_q[1].pre <= io_req.wdata[pwm_gen_pkg::PS_PRE_HI:pwm_gen_pkg::PS_PRE_LO];
        cfg_q[1].div <= io_req.wdata[pwm_gen_pkg::PS_DIV_HI:pwm_gen_pkg::PS_DIV_LO];
      end
      // Bound high and low halves
      if (wr_at(io_req, pwm_gen_pkg::ADDR_B_BOUND_HIGH)) begin
        cfg_q[0].bound[10:3] <= io_req.wdata;
      end
      if (wr_at(io_req, pwm_gen_pkg::ADDR_C_BOUND_HIGH)) begin
        cfg_q[1].bound[10:3] <= io_req.wdata;
      end
      // Reserved low bits are dropped
      if (wr_at(io_req, pwm_gen_pkg::ADDR_B_BOUND_LOW)) begin
        cfg_q[0].bound[2:0] <= {io_req.wdata[pwm_gen_pkg::BND_LO_HI:pwm_gen_pkg::BND_LO_LO],
                                pwm_gen_pkg::BOUND_BIT0};
      end
      if (wr_at(io_req, pwm_gen_pkg::ADDR_C_BOUND_LOW)) begin
        cfg_q[1].bound[2:0] <= {io_req.wdata[pwm_gen_pkg::BND_LO_HI:pwm_gen_pkg::BND_LO_LO],
                                pwm_gen_pkg::BOUND_BIT0};
      end
      // Duty low only stages; avoids a torn duty value
      if (wr_at(io_req, pwm_gen_pkg::ADDR_B_DUTY_LOW)) begin
        cfg_q[0].duty_lo <= io_req.wdata[pwm_gen_pkg::DUTY_LO_HI:pwm_gen_pkg::DUTY_LO_LO];
      end
      if (wr_at(io_req, pwm_gen_pkg::ADDR_C_DUTY_LOW)) begin
        cfg_q[1].duty_lo <= io_req.wdata[pwm_gen_pkg::DUTY_LO_HI:pwm_gen_pkg::DUTY_LO_LO];
      end
      // Duty high commits with staged low bits
      if (wr_at(io_req, pwm_gen_pkg::ADDR_B_DUTY_HIGH)) begin
        cfg_q[0].duty <= {io_req.wdata, cfg_q[0].duty_lo};
      end
      if (wr_at(io_req, pwm_gen_pkg::ADDR_C_DUTY_HIGH)) begin
        cfg_q[1].duty <= {io_req.wdata, cfg_q[1].duty_lo};
      end
    end
  end

  // Channel C control; clear bit drops after one clock cycle
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctl_c_q <= '0;
    end else if (wr_at(io_req, pwm_gen_pkg::ADDR_C_CONTROL)) begin
      // A new write wins over the self-clear
      ctl_c_q.en <= io_req.wdata[pwm_gen_pkg::CTL_EN];
      ctl_c_q.inv <= io_req.wdata[pwm_gen_pkg::CTL_INV];
      ctl_c_q.clr <= io_req.wdata[pwm_gen_pkg::CTL_CLR];
      ctl_c_q.sel <= io_req.wdata[pwm_gen_pkg::CTL_SEL_HI:pwm_gen_pkg::CTL_SEL_LO];
      ctl_c_q.src <= io_req.wdata[pwm_gen_pkg::CTL_SRC];
    end else begin
      // Counter is cleared in the cycle the bit is high
      ctl_c_q.clr <= 1'b0;
    end
  end

  // Readback: only control register reads back
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      io_rdata_q <= pwm_gen_pkg::REG_RESET;
    end else if (io_req.rd && io_req.addr == pwm_gen_pkg::ADDR_C_CONTROL) begin
      // Bit 6 shows the live output level
      io_rdata_q <= {ctl_c_q.en, pwm_level[1], ctl_c_q.inv, ctl_c_q.clr,
                     ctl_c_q.sel, ctl_c_q.src};
    end else begin
      // Write-only and unmapped reads give zero
      io_rdata_q <= pwm_gen_pkg::REG_RESET;
    end
  end

  // Clock selection and step detection
  always_comb begin
    for (int i = 0; i < pwm_gen_pkg::NCHAN; i++) begin
      // Oscillator tick is taken as synchronous here
      src_tick[i] = ctl[i].src ? osc_tick : 1'b1;
      run[i] = ctl[i].en && !ctl[i].clr;
      // At or past the end ends the count, so a shrunk setting never runs it round
      pre_wrap[i] = src_tick[i] && (pre_cnt_q[i] >= pre_end(cfg_q[i].pre));
      tick[i] = run[i] && pre_wrap[i] && (div_cnt_q[i] >= cfg_q[i].div);
      // Wrap at bound back to zero
      cnt_nxt[i] = (cnt_q[i] >= cfg_q[i].bound) ? 11'h000 : cnt_q[i] + 11'h001;
      // Count after this edge; keeps the level in step with the interrupt
      cnt_d[i] = !run[i] ? 11'h000 : (tick[i] ? cnt_nxt[i] : cnt_q[i]);
    end
  end

  // Prescaler, held at zero while idle
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      pre_cnt_q <= '0;
    end else begin
      for (int i = 0; i < pwm_gen_pkg::NCHAN; i++) begin
        if (!run[i] || pre_wrap[i]) begin
          pre_cnt_q[i] <= 6'h00;
        end else if (src_tick[i]) begin
          pre_cnt_q[i] <= pre_cnt_q[i] + 6'h01;
        end
      end
    end
  end

  // Divider: divides prescaled clock by field plus one
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      div_cnt_q <= '0;
    end else begin
      for (int i = 0; i < pwm_gen_pkg::NCHAN; i++) begin
        if (!run[i] || tick[i]) begin
          div_cnt_q[i] <= 5'h00;
        end else if (pre_wrap[i]) begin
          div_cnt_q[i] <= div_cnt_q[i] + 5'h01;
        end
      end
    end
  end

  // Main counter
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_q <= '0;
    end else begin
      for (int i = 0; i < pwm_gen_pkg::NCHAN; i++) begin
        if (!run[i]) begin
          cnt_q[i] <= 11'h000;
        end else if (tick[i]) begin
          cnt_q[i] <= cnt_nxt[i];
        end
      end
    end
  end

  // Interrupt pulse on the step that lands on the target
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_pulse <= '0;
    end else begin
      for (int i = 0; i < pwm_gen_pkg::NCHAN; i++) begin
        if (cfg_q[i].mode) begin
          irq_pulse[i] <= tick[i] && (cnt_nxt[i] == 11'h000);
        end else begin
          irq_pulse[i] <= tick[i] && (cnt_nxt[i] == cfg_q[i].duty);
        end
      end
    end
  end

  // Output level; idle level follows polarity bit
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      pwm_level <= '0;
    end else begin
      for (int i = 0; i < pwm_gen_pkg::NCHAN; i++) begin
        // Level shows the same count as the register, not the one before
        pwm_level[i] <= (ctl[i].en && (cnt_d[i] < cfg_q[i].duty)) ^ ctl[i].inv;
      end
    end
  end

  // Pin routing; B has only three pins
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_out <= '0;
      pin_oe <= '0;
    end else begin
      pin_oe[0] <= pin_map(ctl[0].sel) & pwm_gen_pkg::PIN_MASK_B;
      pin_oe[1] <= pin_map(ctl[1].sel) & pwm_gen_pkg::PIN_MASK_C;
      for (int i = 0; i < pwm_gen_pkg::NCHAN; i++) begin
        pin_out[i] <= {4{(ctl[i].en && (cnt_d[i] < cfg_q[i].duty)) ^ ctl[i].inv}};
      end
    end
  end

  // Checks on channel C
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  AST_IRQ_MATCH: assert property (
    irq_pulse[1] && !cfg_q[1].mode && $stable(cfg_q[1].mode) && $stable(cfg_q[1].duty)
    |-> cnt_q[1] == cfg_q[1].duty)
    else $error("match interrupt without duty match");
  AST_IRQ_ZERO: assert property (
    irq_pulse[1] && cfg_q[1].mode && $stable(cfg_q[1].mode) |-> cnt_q[1] == 11'h000)
    else $error("zero interrupt with nonzero counter");
  AST_PRE4: assert property (
    disable iff (!reset_n || io_req.wr)
    tick[1] && !ctl_c_q.src && cfg_q[1].pre == 2'h1 && cfg_q[1].div == 5'h01
    && !io_req.wr |-> ##1 !tick[1] [*7] ##1 tick[1])
    else $error("prescale by four spacing wrong");
  AST_DIV: assert property (
    $stable(cfg_q[1].div) && $past(div_cnt_q[1]) <= $past(cfg_q[1].div)
    |-> div_cnt_q[1] <= cfg_q[1].div)
    else $error("divider passed its setting");
  AST_BOUND_HI: assert property (
    wr_at(io_req, pwm_gen_pkg::ADDR_C_BOUND_HIGH) |=> cfg_q[1].bound[10:3] == $past(io_req.wdata))
    else $error("bound high not taken");
  AST_BOUND_LO: assert property (
    wr_at(io_req, pwm_gen_pkg::ADDR_C_BOUND_LOW) |=> cfg_q[1].bound[2:1] == $past(io_req.wdata[7:6]))
    else $error("bound low not taken");
  AST_DUTY_COMMIT: assert property (
    wr_at(io_req, pwm_gen_pkg::ADDR_C_DUTY_LOW) ##1 !io_req.wr
    ##1 wr_at(io_req, pwm_gen_pkg::ADDR_C_DUTY_HIGH)
    |=> cfg_q[1].duty == {$past(io_req.wdata), $past(io_req.wdata[7:5], 3)})
    else $error("duty not combined from low then high");
  AST_DUTY_HOLD: assert property (
    wr_at(io_req, pwm_gen_pkg::ADDR_C_DUTY_LOW) |=> $stable(cfg_q[1].duty))
    else $error("duty changed on low write");
  AST_DISABLED: assert property (
    !ctl_c_q.en |=> cnt_q[1] == 11'h000 && !irq_pulse[1] && pwm_level[1] == $past(ctl_c_q.inv))
    else $error("disabled channel still running");
  AST_CLEAR: assert property (
    ctl_c_q.clr |=> cnt_q[1] == 11'h000 && (!ctl_c_q.clr || $past(io_req.wr)))
    else $error("counter clear failed");
  AST_PIN: assert property (
    ctl_c_q.sel == pwm_gen_pkg::SEL_NONE && $stable(ctl_c_q.sel) |=> pin_oe[1] == 4'h0)
    else $error("pin driven while routing off");
  AST_SRC: assert property (
    ctl_c_q.src && !osc_tick |-> !tick[1])
    else $error("stepped without oscillator tick");
  AST_WRAP: assert property (
    tick[1] && cnt_q[1] == cfg_q[1].bound |=> cnt_q[1] == 11'h000)
    else $error("counter did not wrap at bound");
  AST_LEVEL: assert property (
    ctl_c_q.en |=> pwm_level[1] == ((cnt_q[1] < $past(cfg_q[1].duty)) ^ $past(ctl_c_q.inv)))
    else $error("level out of step with counter");
  AST_RDATA: assert property (
    io_req.rd && io_req.addr == pwm_gen_pkg::ADDR_C_CONTROL
    |=> io_rdata[7] == $past(ctl_c_q.en) && io_rdata[5] == $past(ctl_c_q.inv))
    else $error("control readback wrong");
  AST_OSC_HOLD: assert property (
    ctl_c_q.en && ctl_c_q.src && !ctl_c_q.clr && !osc_tick |=> $stable(cnt_q[1]))
    else $error("counter moved without oscillator tick");

  // Channel B shares the logic; spot checks on its own registers
  AST_B_BOUND_HI: assert property (
    wr_at(io_req, pwm_gen_pkg::ADDR_B_BOUND_HIGH) |=> cfg_q[0].bound[10:3] == $past(io_req.wdata))
    else $error("channel B bound high not taken");
  AST_B_IRQ_MATCH: assert property (
    irq_pulse[0] && !cfg_q[0].mode && $stable(cfg_q[0].mode) && $stable(cfg_q[0].duty)
    |-> cnt_q[0] == cfg_q[0].duty)
    else $error("channel B match interrupt without duty match");
  AST_B_WRAP: assert property (
    tick[0] && cnt_q[0] == cfg_q[0].bound |=> cnt_q[0] == 11'h000)
    else $error("channel B counter did not wrap at bound");

  COV_IRQ_MATCH: cover property (irq_pulse[1] && !cfg_q[1].mode);
  COV_IRQ_ZERO: cover property (irq_pulse[1] && cfg_q[1].mode);
  COV_PIN3: cover property (pin_oe[1] == 4'h8 && pin_out[1][3]);
  COV_OSC: cover property (tick[1] && ctl_c_q.src);
  COV_CLEAR: cover property (ctl_c_q.clr ##1 !ctl_c_q.clr);

endmodule : pwm_gen_channels

// *** pwm_gen_pkg.sv ***
// Constants and types for the two-channel PWM generator
package pwm_gen_pkg;
  // I/O addresses
  localparam logic [5:0] ADDR_B_PRESCALE = 6'h27;
  localparam logic [5:0] ADDR_B_DUTY_HIGH = 6'h28;
  localparam logic [5:0] ADDR_B_DUTY_LOW = 6'h29;
  localparam logic [5:0] ADDR_B_BOUND_HIGH = 6'h2A;
  localparam logic [5:0] ADDR_B_BOUND_LOW = 6'h2B;
  localparam logic [5:0] ADDR_C_CONTROL = 6'h2C;
  localparam logic [5:0] ADDR_C_PRESCALE = 6'h2D;
  localparam logic [5:0] ADDR_C_DUTY_HIGH = 6'h2E;
  localparam logic [5:0] ADDR_C_DUTY_LOW = 6'h2F;
  localparam logic [5:0] ADDR_C_BOUND_HIGH = 6'h30;
  localparam logic [5:0] ADDR_C_BOUND_LOW = 6'h31;
  // Control register fields
  localparam int CTL_EN = 7;
  localparam int CTL_INV = 5;
  localparam int CTL_CLR = 4;
  localparam int CTL_SEL_HI = 3;
  localparam int CTL_SEL_LO = 1;
  localparam int CTL_SRC = 0;
  // Prescale register fields
  localparam int PS_MODE = 7;
  localparam int PS_PRE_HI = 6;
  localparam int PS_PRE_LO = 5;
  localparam int PS_DIV_HI = 4;
  localparam int PS_DIV_LO = 0;
  // Low registers: upper bits carry data
  localparam int BND_LO_HI = 7;
  localparam int BND_LO_LO = 6;
  localparam int DUTY_LO_HI = 7;
  localparam int DUTY_LO_LO = 5;
  // Bound bit 0 has no register bit
  localparam logic BOUND_BIT0 = 1'b0;
  // Output pin select codes
  localparam logic [2:0] SEL_NONE = 3'h0;
  localparam logic [2:0] SEL_PIN0 = 3'h1;
  localparam logic [2:0] SEL_PIN1 = 3'h3;
  localparam logic [2:0] SEL_PIN2 = 3'h4;
  localparam logic [2:0] SEL_PIN3 = 3'h5;
  // Channel B has no fourth pin
  localparam logic [3:0] PIN_MASK_B = 4'h7;
  localparam logic [3:0] PIN_MASK_C = 4'hF;
  // Prescaler terminal counts for /1 /4 /16 /64
  localparam logic [5:0] PRE_END_1 = 6'h00;
  localparam logic [5:0] PRE_END_4 = 6'h03;
  localparam logic [5:0] PRE_END_16 = 6'h0F;
  localparam logic [5:0] PRE_END_64 = 6'h3F;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam int NCHAN = 2;
  localparam int CH_B = 0;
  localparam int CH_C = 1;
  // Per-channel control bits
  typedef struct packed {
    logic en;
    logic inv;
    logic clr;
    logic [2:0] sel;
    logic src;
  } chan_ctl_t;
  // Per-channel timing setup
  typedef struct packed {
    logic mode;
    logic [1:0] pre;
    logic [4:0] div;
    logic [10:0] bound;
    logic [10:0] duty;
    logic [2:0] duty_lo;
  } chan_cfg_t;
  // Core I/O access
  typedef struct packed {
    logic [5:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } io_req_t;
endpackage : pwm_gen_pkg

// *** test_pwm_gen_channels.sv ***
// Self-checking bench for the two PWM generator channels
`timescale 1ns/100ps
module test_pwm_gen_channels;
  // Stimulus, all given a value at time zero
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  pwm_gen_pkg::io_req_t io_req = '0;
  logic osc_tick = 1'b0;
  pwm_gen_pkg::chan_ctl_t chan_b_ctl = '0;
  // Observed outputs
  logic [7:0] io_rdata;
  logic [1:0] pwm_level;
  logic [1:0] irq_pulse;
  logic [1:0][3:0] pin_out;
  logic [1:0][3:0] pin_oe;
  // Bench state
  int bad_count = 0;
  int cmp_count = 0;
  logic osc_on = 1'b0;
  logic [1:0] osc_ph = 2'h0;
  logic [7:0] rd_val;
  // Pin enables per select code; reserved codes drive nothing
  logic [3:0] sel_tbl [8] = '{4'h0, 4'h1, 4'h0, 4'h2, 4'h4, 4'h8, 4'h0, 4'h0};

  pwm_gen_channels uut (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .io_req(io_req),
    .io_rdata(io_rdata),
    .osc_tick(osc_tick),
    .chan_b_ctl(chan_b_ctl),
    .pwm_level(pwm_level),
    .irq_pulse(irq_pulse),
    .pin_out(pin_out),
    .pin_oe(pin_oe)
  );

  // 10 MHz core clock
  always #50 sys_clk = ~sys_clk;

  // Oscillator stand-in: a tick every third cycle, only when switched on
  always @(posedge sys_clk) begin
    osc_ph <= (osc_ph == 2'h2) ? 2'h0 : osc_ph + 2'h1;
    osc_tick <= osc_on && (osc_ph == 2'h2);
  end

  // One comparison; case inequality so unknowns never match
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %0h seen %0h", name, exp, seen);
    end
  endtask : check

  // Verdict and end of run
  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : final_report

  // Register write: one-cycle strobe, then an idle cycle
  task automatic wr(input logic [5:0] addr, input logic [7:0] data);
    @(posedge sys_clk);
    io_req <= '{addr: addr, wdata: data, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk);
    io_req <= '0;
  endtask : wr

  // Register read: data stands for the cycle after the taking edge
  task automatic rd(input logic [5:0] addr, output logic [7:0] data);
    @(posedge sys_clk);
    io_req <= '{addr: addr, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk);
    io_req <= '0;
    #10;
    data = io_rdata;
  endtask : rd

  // Five timing registers of one channel, duty low before high
  task automatic cfg(input int ch, input logic [7:0] bh, bl, dl, dh, ps);
    if (ch == pwm_gen_pkg::CH_C) begin
      wr(pwm_gen_pkg::ADDR_C_BOUND_HIGH, bh);
      wr(pwm_gen_pkg::ADDR_C_BOUND_LOW, bl);
      wr(pwm_gen_pkg::ADDR_C_DUTY_LOW, dl);
      wr(pwm_gen_pkg::ADDR_C_DUTY_HIGH, dh);
      wr(pwm_gen_pkg::ADDR_C_PRESCALE, ps);
    end else begin
      wr(pwm_gen_pkg::ADDR_B_BOUND_HIGH, bh);
      wr(pwm_gen_pkg::ADDR_B_BOUND_LOW, bl);
      wr(pwm_gen_pkg::ADDR_B_DUTY_LOW, dl);
      wr(pwm_gen_pkg::ADDR_B_DUTY_HIGH, dh);
      wr(pwm_gen_pkg::ADDR_B_PRESCALE, ps);
    end
  endtask : cfg

  // Settle n cycles, then count irq, level and irq-with-level over n cycles.
  // Windows are whole periods, so counts do not depend on phase.
  task automatic measure(input int ch, input int n, input int e_irq, e_lvl, e_both);
    logic [15:0] n_irq = '0;
    logic [15:0] n_lvl = '0;
    logic [15:0] n_both = '0;
    repeat (n) @(posedge sys_clk);
    repeat (n) begin
      @(posedge sys_clk);
      #10;
      n_irq += 16'(irq_pulse[ch] === 1'b1);
      n_lvl += 16'(pwm_level[ch] === 1'b1);
      n_both += 16'(irq_pulse[ch] === 1'b1 && pwm_level[ch] === 1'b1);
    end
    check("irq count", n_irq, 16'(e_irq));
    check("level count", n_lvl, 16'(e_lvl));
    check("irq at high level", n_both, 16'(e_both));
  endtask : measure

  // Reset for 16 cycles, then idle outputs and cleared control
  task automatic do_reset();
    @(posedge sys_clk);
    reset_n <= 1'b0;
    chan_b_ctl <= '0; // Channel B control lives outside; idle it too
    repeat (16) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(posedge sys_clk);
    #10;
    check("level after reset", 16'(pwm_level), 16'h0000);
    check("pins after reset", 16'(pin_oe), 16'h0000);
    rd(pwm_gen_pkg::ADDR_C_CONTROL, rd_val);
    check("control reset", 16'(rd_val), 16'h0000);
  endtask : do_reset

  // Hang guard, well beyond the longest sequence
  initial begin
    #10_000_000;
    bad_count++;
    final_report();
  end

  // Main sequence
  initial begin
    do_reset();
    rd(pwm_gen_pkg::ADDR_C_PRESCALE, rd_val);
    check("write-only read", 16'(rd_val), 16'h0000);
    rd(6'h32, rd_val);
    check("unmapped read", 16'(rd_val), 16'h0000);
    $display("test reset done");
    // Bound 4 (reserved low bits set), duty 2, mode match
    cfg(pwm_gen_pkg::CH_C, 8'h00, 8'hBF, 8'h5F, 8'h00, 8'h00);
    wr(pwm_gen_pkg::ADDR_C_CONTROL, 8'h82);
    measure(pwm_gen_pkg::CH_C, 50, 10, 20, 0);
    $display("test match mode done");
    // Zero mode; unmapped writes must not disturb the channel
    wr(pwm_gen_pkg::ADDR_C_PRESCALE, 8'h80);
    wr(6'h32, 8'h00);
    wr(6'h26, 8'h00);
    measure(pwm_gen_pkg::CH_C, 50, 10, 20, 10);
    $display("test zero mode done");
    // Low half alone changes nothing until the high half lands
    wr(pwm_gen_pkg::ADDR_C_DUTY_LOW, 8'hE0);
    measure(pwm_gen_pkg::CH_C, 50, 10, 20, 10);
    wr(pwm_gen_pkg::ADDR_C_DUTY_HIGH, 8'h00);
    measure(pwm_gen_pkg::CH_C, 50, 10, 50, 10);
    $display("test duty commit done");
    // Bound 16, duty 9 exercises the high halves
    cfg(pwm_gen_pkg::CH_C, 8'h02, 8'h00, 8'h20, 8'h01, 8'h00);
    measure(pwm_gen_pkg::CH_C, 68, 4, 36, 0);
    $display("test high halves done");
    // Every prescale code with divider 1: total divide is 2 * prescale
    cfg(pwm_gen_pkg::CH_C, 8'h00, 8'h80, 8'h40, 8'h00, 8'h00);
    for (int p = 0; p < 4; p++) begin
      wr(pwm_gen_pkg::ADDR_C_PRESCALE, {1'b0, 2'(p), 5'h01});
      measure(pwm_gen_pkg::CH_C, 20 << (2 * p), 2, 8 << (2 * p), 0);
    end
    $display("test prescale done");
    // Inverted output
    wr(pwm_gen_pkg::ADDR_C_PRESCALE, 8'h00);
    wr(pwm_gen_pkg::ADDR_C_CONTROL, 8'hA2);
    measure(pwm_gen_pkg::CH_C, 50, 10, 30, 10);
    $display("test invert done");
    // Disabled: no interrupts, level follows the invert bit
    wr(pwm_gen_pkg::ADDR_C_CONTROL, 8'h22);
    measure(pwm_gen_pkg::CH_C, 20, 0, 20, 0);
    check("pin level C", 16'(pin_out[1]), 16'h000F);
    wr(pwm_gen_pkg::ADDR_C_CONTROL, 8'h02);
    measure(pwm_gen_pkg::CH_C, 20, 0, 0, 0);
    check("pin level C", 16'(pin_out[1]), 16'h0000);
    $display("test disable done");
    // Clear written back to back holds the count at zero, then self-clears
    wr(pwm_gen_pkg::ADDR_C_CONTROL, 8'h82);
    @(posedge sys_clk);
    io_req <= '{addr: pwm_gen_pkg::ADDR_C_CONTROL, wdata: 8'h92, wr: 1'b1, rd: 1'b0};
    measure(pwm_gen_pkg::CH_C, 15, 0, 15, 0);
    @(posedge sys_clk);
    io_req <= '0;
    rd(pwm_gen_pkg::ADDR_C_CONTROL, rd_val);
    check("clear bit", 16'(rd_val & 8'hBF), 16'h0082);
    $display("test counter clear done");
    // Oscillator source: five steps of three cycles per period
    @(posedge sys_clk);
    osc_on <= 1'b1;
    wr(pwm_gen_pkg::ADDR_C_CONTROL, 8'h83);
    measure(pwm_gen_pkg::CH_C, 45, 3, 18, 0);
    @(posedge sys_clk);
    osc_on <= 1'b0;
    $display("test clock source done");
    // Every select code on both channels; B has no fourth pin
    for (int c = 0; c < 8; c++) begin
      @(posedge sys_clk);
      chan_b_ctl <= '{en: 1'b1, inv: 1'b0, clr: 1'b0, sel: 3'(c), src: 1'b0};
      wr(pwm_gen_pkg::ADDR_C_CONTROL, {4'h8, 3'(c), 1'b0});
      repeat (3) @(posedge sys_clk);
      #10;
      check("pin enable C", 16'(pin_oe[1]), 16'(sel_tbl[c]));
      check("pin enable B", 16'(pin_oe[0]), 16'(sel_tbl[c] & 4'h7));
    end
    $display("test pin select done");
    // Channel B: bound 4, duty 3, match mode
    @(posedge sys_clk);
    chan_b_ctl <= '{en: 1'b1, inv: 1'b0, clr: 1'b0, sel: 3'h1, src: 1'b0};
    cfg(pwm_gen_pkg::CH_B, 8'h00, 8'h80, 8'h60, 8'h00, 8'h00);
    measure(pwm_gen_pkg::CH_B, 50, 10, 30, 0);
    $display("test channel B done");
    // Reset in mid-run returns everything to idle
    do_reset();
    $display("test second reset done");
    final_report();
  end
endmodule : test_pwm_gen_channels
